// >>> rtl/arith_env_and_status_flags.v
`include "arith_defs.vh"

module arith_env_and_status_flags (
   input  wire        sys_clk,          // Core clock
   input  wire        rst_n,            // Async reset, active low
   input  wire        spr_wr_en,        // Special-register move write
   input  wire [7:0]  spr_wr_num,       // Destination register number
   input  wire [31:0] spr_wr_data,      // Source word
   input  wire        spr_rd_en,        // Special-register move read
   input  wire [7:0]  spr_rd_num,       // Source register number
   output reg  [31:0] spr_rd_data,      // Read word, one cycle later
   input  wire        alu_valid,        // ALU operation this cycle
   input  wire [2:0]  alu_kind,         // Operation kind
   input  wire [31:0] alu_a,            // First operand
   input  wire [31:0] alu_b,            // Second operand
   input  wire [31:0] logic_result,     // Result of a logical op
   input  wire        ones_complement,  // Subtract with no carry-in
   input  wire        step_shift_in,    // Bit shifted in by a step
   input  wire        div_end_force,    // Divide end sets flag to 1
   output reg  [31:0] alu_result,       // Word written to register
   input  wire        ls_set_ptr,       // Load/store with set-pointer
   input  wire        endian_select,    // Byte-order configuration
   output wire [1:0]  byte_lane,        // Selected byte lane, 3 = MSB
   output wire        half_lane,        // Selected half, 1 = upper
   input  wire [31:0] funnel_hi,        // Upper funnel operand
   input  wire [31:0] funnel_lo,        // Lower funnel operand
   output reg  [31:0] funnel_out,       // Extracted word
   output wire        fast_float_en,    // Fast floating mode
   output wire [1:0]  round_mode_field, // Default rounding
   output wire        div_sub_sel,      // Next divide step subtracts
   input  wire        fp_exc_valid,     // Float exception report
   input  wire [5:0]  fp_exc_flags,     // Div0,inex,undf,ovfl,rsvd,invl
   output reg         fp_trap,          // Float exception trap pulse
   input  wire        int_div_valid,    // Integer divide finished
   input  wire        int_div_zero,     // Divisor was zero
   input  wire        int_div_ovf,      // Quotient overflowed 32 bits
   input  wire        int_mul_valid,    // Integer multiply finished
   input  wire        int_mul_ovf,      // Product overflowed 32 bits
   output reg         range_trap        // Out-of-range trap pulse
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [`FE_WIDTH-1:0] float_environment_r;
   reg [1:0]           whole_number_traps_r;
   reg [`ST_WIDTH-1:0] status_r;
   reg [`ST_WIDTH-1:0] status_nxt;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Word is all zero
   function is_zero;
      input [31:0] w;
      begin
         is_zero = (w == 32'h0000_0000);
      end
   endfunction

   // Register number decodes to the status word or one alias
   function hits;
      input [7:0] num;
      input [7:0] alias_num;
      begin
         hits = (num == `SPR_ARITH_STATUS) || (num == alias_num);
      end
   endfunction

   // A trap cause survives only while its mask bit is clear
   function gated;
      input cause;
      input mask;
      begin
         gated = cause & ~mask;
      end
   endfunction

   // ------------------------------------------------------------
   // Field views
   // ------------------------------------------------------------
   wire       divide_step_flag = status_r[`ST_DF_BIT];
   wire       carry_flag       = status_r[`ST_C_BIT];
   wire [1:0] byte_select_pointer = status_r[`ST_BP_HI:`ST_BP_LO];
   wire [4:0] shift_amount_field  = status_r[`ST_FC_HI:`ST_FC_LO];

   assign fast_float_en    = float_environment_r[`FE_FAST_BIT];
   assign round_mode_field =
      float_environment_r[`FE_RND_HI:`FE_RND_LO];
   // A set divide flag makes the next step subtract
   assign div_sub_sel      = divide_step_flag;

   // Big-endian counts byte 0 from the top lane
   assign byte_lane = endian_select ? byte_select_pointer
                                    : ~byte_select_pointer;
   assign half_lane = byte_lane[1];

   // ------------------------------------------------------------
   // Adder
   // ------------------------------------------------------------
   reg         sub_op;
   reg         carry_in;
   reg  [31:0] b_op;
   reg  [32:0] sum;
   reg  [31:0] written;
   reg         carry_top;

   // Subtract adds the complement of b; one's form drops the +1
   always @* begin
      sub_op   = 1'b0;
      carry_in = 1'b0;
      case (alu_kind)
         `OP_ADD:   carry_in = 1'b0;
         `OP_ADDC:  carry_in = carry_flag;
         `OP_SUB: begin
            sub_op   = 1'b1;
            carry_in = ~ones_complement;
         end
         `OP_SUBC: begin
            sub_op   = 1'b1;
            carry_in = carry_flag;
         end
         `OP_MSTEP: carry_in = 1'b0;
         `OP_DSTEP, `OP_DEND: begin
            sub_op   = divide_step_flag;
            carry_in = divide_step_flag;
         end
         default:   carry_in = 1'b0;
      endcase
      b_op      = sub_op ? ~alu_b : alu_b;
      sum       = {1'b0, alu_a} + {1'b0, b_op} + {32'h0, carry_in};
      // Carry into bit 31 recovered from the sum bit and both inputs
      carry_top = alu_a[31] ^ b_op[31] ^ sum[31];
      if (alu_kind == `OP_LOGIC)
         written = logic_result;
      else if (alu_kind == `OP_MSTEP || alu_kind == `OP_DSTEP)
         written = {sum[30:0], step_shift_in};
      else
         written = sum[31:0];
   end

   // ------------------------------------------------------------
   // Status word next value
   // ------------------------------------------------------------
   // Moves land first; a same-cycle ALU op then updates its flags,
   // so the instruction result is never lost behind a move.
   always @* begin
      status_nxt = status_r;
      if (spr_wr_en) begin
         if (spr_wr_num == `SPR_ARITH_STATUS)
            status_nxt = spr_wr_data[`ST_WIDTH-1:0];
         if (hits(spr_wr_num, `SPR_BYTE_PTR_ALIAS))
            status_nxt[`ST_BP_HI:`ST_BP_LO] =
               spr_wr_data[`ST_BP_HI:`ST_BP_LO];
         if (hits(spr_wr_num, `SPR_SHIFT_ALIAS))
            status_nxt[`ST_FC_HI:`ST_FC_LO] =
               spr_wr_data[`ST_FC_HI:`ST_FC_LO];
      end
      if (ls_set_ptr)
         status_nxt[`ST_BP_HI:`ST_BP_LO] =
            {~endian_select, ~endian_select};
      if (alu_valid) begin
         if (alu_kind == `OP_LOGIC) begin
            status_nxt[`ST_N_BIT] = logic_result[31];
            status_nxt[`ST_Z_BIT] = is_zero(logic_result);
         end else begin
            status_nxt[`ST_V_BIT] = sum[32] ^ carry_top;
            status_nxt[`ST_N_BIT] = sum[31];
            status_nxt[`ST_Z_BIT] = is_zero(written);
            status_nxt[`ST_C_BIT] = sum[32];
            if (alu_kind == `OP_DEND)
               status_nxt[`ST_DF_BIT] =
                  div_end_force | ~sum[32];
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Float environment and trap masks change only on whole moves
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r             <= `ST_RESET;
         float_environment_r  <= `FE_RESET;
         whole_number_traps_r <= `WT_RESET;
      end else begin
         status_r <= status_nxt;
         if (spr_wr_en && spr_wr_num == `SPR_FLOAT_ENV)
            float_environment_r <=
               spr_wr_data[`FE_WIDTH-1:0];
         if (spr_wr_en && spr_wr_num == `SPR_WHOLE_TRAPS)
            whole_number_traps_r <= spr_wr_data[1:0];
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   // Narrow registers zero-extend; unmapped numbers read zero
   // Alias numbers show only their own field, at its status position
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         spr_rd_data <= 32'h0000_0000;
      end else if (spr_rd_en) begin
         case (spr_rd_num)
            `SPR_ARITH_STATUS:
               spr_rd_data <= {20'h0_0000, status_r};
            `SPR_BYTE_PTR_ALIAS:
               spr_rd_data <= {25'h000_0000, byte_select_pointer, 5'h00};
            `SPR_SHIFT_ALIAS:
               spr_rd_data <= {27'h000_0000, shift_amount_field};
            `SPR_FLOAT_ENV:
               spr_rd_data <= {23'h00_0000, float_environment_r};
            `SPR_WHOLE_TRAPS:
               spr_rd_data <= {30'h0000_0000, whole_number_traps_r};
            default:
               spr_rd_data <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Result, funnel and traps
   // ------------------------------------------------------------
   // Funnel output refreshes every cycle from the current count, so
   // a count move shows one cycle after it lands
   wire [63:0] funnel_join  = {funnel_hi, funnel_lo};
   wire [63:0] funnel_shift = funnel_join << shift_amount_field;

   // Each float cause is dropped when its own mask bit is set; the
   // cause order on fp_exc_flags matches the mask bits, so the same
   // field positions index both. Masked causes leave no record here,
   // the sticky status is kept outside this block.
   wire fp_divz_live = gated(fp_exc_flags[`FE_DIVZ_BIT],
                             float_environment_r[`FE_DIVZ_BIT]);
   wire fp_inex_live = gated(fp_exc_flags[`FE_INEX_BIT],
                             float_environment_r[`FE_INEX_BIT]);
   wire fp_undf_live = gated(fp_exc_flags[`FE_UNDF_BIT],
                             float_environment_r[`FE_UNDF_BIT]);
   wire fp_ovfl_live = gated(fp_exc_flags[`FE_OVFL_BIT],
                             float_environment_r[`FE_OVFL_BIT]);
   wire fp_rsvd_live = gated(fp_exc_flags[`FE_RSVD_BIT],
                             float_environment_r[`FE_RSVD_BIT]);
   wire fp_invl_live = gated(fp_exc_flags[`FE_INVL_BIT],
                             float_environment_r[`FE_INVL_BIT]);
   wire fp_any_live  = fp_divz_live | fp_inex_live | fp_undf_live |
                       fp_ovfl_live | fp_rsvd_live | fp_invl_live;

   // Divide by zero traps whatever the overflow mask holds
   wire div_trap = int_div_valid &
                   (int_div_zero |
                    gated(int_div_ovf,
                          whole_number_traps_r[`WT_DIV_OVF_BIT]));
   wire mul_trap = int_mul_valid &
                   gated(int_mul_ovf,
                         whole_number_traps_r[`WT_MUL_OVF_BIT]);

   // Registered outputs keep the traps glitch-free toward control
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alu_result <= 32'h0000_0000;
         fp_trap    <= 1'b0;
         range_trap <= 1'b0;
      end else begin
         if (alu_valid)
            alu_result <= written;
         fp_trap    <= fp_exc_valid & fp_any_live;
         range_trap <= div_trap | mul_trap;
      end
   end

   // Funnel word is registered every cycle, not only on an extract
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         funnel_out <= 32'h0000_0000;
      end else begin
         funnel_out <= funnel_shift[63:32];
      end
   end

endmodule // arith_env_and_status_flags

// >>> rtl/arith_defs.vh
`ifndef ARITH_DEFS_VH
`define ARITH_DEFS_VH
// ---------------------------------------------------------------
// Special-register numbers
// ---------------------------------------------------------------
`define SPR_ARITH_STATUS   8'h84
`define SPR_BYTE_PTR_ALIAS 8'h85
`define SPR_SHIFT_ALIAS    8'h86
`define SPR_FLOAT_ENV      8'hA0
`define SPR_WHOLE_TRAPS    8'hA1
// ---------------------------------------------------------------
// Float environment fields
// ---------------------------------------------------------------
`define FE_FAST_BIT        8
`define FE_RND_HI          7
`define FE_RND_LO          6
`define FE_DIVZ_BIT        5
`define FE_INEX_BIT        4
`define FE_UNDF_BIT        3
`define FE_OVFL_BIT        2
`define FE_RSVD_BIT        1
`define FE_INVL_BIT        0
`define FE_WIDTH           9
`define FE_RESET           9'h000
// ---------------------------------------------------------------
// Whole-number trap mask fields
// ---------------------------------------------------------------
`define WT_DIV_OVF_BIT     1
`define WT_MUL_OVF_BIT     0
`define WT_RESET           2'h0
// ---------------------------------------------------------------
// Status word fields
// ---------------------------------------------------------------
`define ST_DF_BIT          11
`define ST_V_BIT           10
`define ST_N_BIT           9
`define ST_Z_BIT           8
`define ST_C_BIT           7
`define ST_BP_HI           6
`define ST_BP_LO           5
`define ST_FC_HI           4
`define ST_FC_LO           0
`define ST_WIDTH           12
`define ST_RESET           12'h000
// ---------------------------------------------------------------
// Round modes
// ---------------------------------------------------------------
`define RND_NEAREST        2'h0
`define RND_MINUS_INF      2'h1
`define RND_PLUS_INF       2'h2
`define RND_ZERO           2'h3
// ---------------------------------------------------------------
// ALU operation kinds
// ---------------------------------------------------------------
`define OP_ADD             3'h0
`define OP_ADDC            3'h1
`define OP_SUB             3'h2
`define OP_SUBC            3'h3
`define OP_LOGIC           3'h4
`define OP_MSTEP           3'h5
`define OP_DSTEP           3'h6
`define OP_DEND            3'h7
`endif

// >>> dv/arith_flags_chk.sv
`include "arith_defs.vh"

module arith_flags_chk (
   input logic        sys_clk,          // Clock
   input logic        rst_n,            // Reset, low
   input logic        spr_wr_en,        // Move write
   input logic [7:0]  spr_wr_num,       // Target
   input logic [31:0] spr_wr_data,      // Data
   input logic        fast_float_en,    // Fast mode
   input logic [1:0]  round_mode_field, // Rounding
   input logic        fp_exc_valid,     // Float report
   input logic [5:0]  fp_exc_flags,     // Causes
   input logic        fp_trap,          // Float trap
   input logic        int_div_valid,    // Divide done
   input logic        int_div_zero,     // Zero divisor
   input logic        int_mul_valid,    // Multiply done
   input logic        range_trap,       // Range trap
   input logic        alu_valid,        // Op strobe
   input logic [2:0]  alu_kind,         // Op kind
   input logic [31:0] alu_a,            // Operand A
   input logic [31:0] alu_b,            // Operand B
   input logic [31:0] alu_result,       // Written word
   input logic        ls_set_ptr,       // Pointer load
   input logic        endian_select,    // Byte order
   input logic [1:0]  byte_lane,        // Lane
   input logic        div_end_force,    // Force flag
   input logic        div_sub_sel       // Subtract next
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks share the core clock and its reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   AST_FAST_FLOAT: assert property (
      spr_wr_en && spr_wr_num == `SPR_FLOAT_ENV
      |=> fast_float_en == $past(spr_wr_data[8]))
      else $error("fast float select not taken from write");
   AST_ROUND_MODE: assert property (
      spr_wr_en && spr_wr_num == `SPR_FLOAT_ENV
      |=> round_mode_field == $past(spr_wr_data[7:6]))
      else $error("round mode not taken from write");
   AST_FP_QUIET: assert property (
      (!fp_exc_valid || fp_exc_flags == 6'h00) |=> !fp_trap)
      else $error("float trap without a cause");
   AST_DIV_ZERO_TRAP: assert property (
      int_div_valid && int_div_zero |=> range_trap)
      else $error("divide by zero did not trap");
   AST_RANGE_QUIET: assert property (
      !int_div_valid && !int_mul_valid |=> !range_trap)
      else $error("range trap without an operation");
   AST_ADD_RESULT: assert property (
      alu_valid && alu_kind == `OP_ADD
      |=> alu_result == $past(alu_a) + $past(alu_b))
      else $error("add result wrong");
   AST_PTR_LOAD: assert property (
      ls_set_ptr ##1 $stable(endian_select) |-> byte_lane == 2'h0)
      else $error("pointer load gave wrong lane");
   AST_DIV_END_FORCE: assert property (
      alu_valid && alu_kind == `OP_DEND && div_end_force
      |=> div_sub_sel)
      else $error("forced divide end left flag clear");
endmodule // arith_flags_chk

bind arith_env_and_status_flags arith_flags_chk i_arith_flags_chk (.*);

// >>> dv/exec_unit_model.sv
module exec_unit_model (
   input  logic        sys_clk,       // Clock
   output logic        alu_valid,     // Op strobe
   output logic [2:0]  alu_kind,      // Op kind
   output logic [31:0] alu_a,         // Operand A
   output logic [31:0] alu_b,         // Operand B
   output logic [31:0] logic_result,  // Logic value
   output logic        div_end_force  // Force flag
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      alu_valid = 1'b0;
      alu_kind = 3'h0;
      alu_a = 32'h0;
      alu_b = 32'h0;
      logic_result = 32'h0;
      div_end_force = 1'b0;
   end
   // One op per call; operands move with the strobe only
   task automatic issue(logic [2:0] k, logic [31:0] a, logic [31:0] b,
                        logic [31:0] lr, logic f);
      @(posedge sys_clk);
      #1;
      alu_valid = 1'b1;
      alu_kind = k;
      alu_a = a;
      alu_b = b;
      logic_result = lr;
      div_end_force = f;
      @(posedge sys_clk);
      #1;
      alu_valid = 1'b0;
      alu_a = ~a;
      alu_b = ~b;
   endtask
endmodule // exec_unit_model

// >>> dv/test_arith_env_and_status_flags.sv
`include "arith_defs.vh"

module test_arith_env_and_status_flags;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst_n = 1'b0, spr_wr_en = 1'b0, spr_rd_en = 1'b0;
   logic [7:0] spr_wr_num = 8'h00, spr_rd_num = 8'h00;
   logic [31:0] spr_wr_data = 32'h0;
   logic [31:0] funnel_hi = 32'h12345678, funnel_lo = 32'h9ABCDEF0;
   logic ones_complement = 1'b0, step_shift_in = 1'b0, ls_set_ptr = 1'b0;
   logic endian_select = 1'b0, fp_exc_valid = 1'b0, int_div_valid = 1'b0;
   logic int_div_zero = 1'b0, int_div_ovf = 1'b0, int_mul_valid = 1'b0;
   logic int_mul_ovf = 1'b0;
   logic [5:0] fp_exc_flags = 6'h00;
   wire [31:0] spr_rd_data, alu_result, funnel_out, alu_a, alu_b, logic_result;
   wire [2:0] alu_kind;
   wire [1:0] byte_lane, round_mode_field;
   wire half_lane, fast_float_en, div_sub_sel, fp_trap, range_trap;
   wire alu_valid, div_end_force;
   int miscompares = 0, num_checks = 0, cycles = 0;

   arith_env_and_status_flags i_arith_env_and_status_flags (.*);
   exec_unit_model i_exec_unit_model (.sys_clk(sys_clk), .alu_valid(alu_valid),
      .alu_kind(alu_kind), .alu_a(alu_a), .alu_b(alu_b),
      .logic_result(logic_result), .div_end_force(div_end_force));

   always #5 sys_clk = ~sys_clk;
   // Runaway guard, far above the roughly 145 cycles needed
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic spr_wr(logic [7:0] n, logic [31:0] d);
      @(posedge sys_clk);
      #1;
      spr_wr_en = 1'b1;
      spr_wr_num = n;
      spr_wr_data = d;
      @(posedge sys_clk);
      #1;
      spr_wr_en = 1'b0;
   endtask
   task automatic spr_rd(logic [7:0] n, logic [31:0] exp);
      @(posedge sys_clk);
      #1;
      spr_rd_en = 1'b1;
      spr_rd_num = n;
      @(posedge sys_clk);
      #1;
      spr_rd_en = 1'b0;
      check("spr_rd_data", exp, spr_rd_data);
   endtask
   // Trap inputs last one cycle; the pulse is looked at in its own cycle
   task automatic trap(logic fv, logic [5:0] f, logic dv, logic dz,
                       logic mv, logic ov, logic efp, logic erg);
      @(posedge sys_clk);
      #1;
      {fp_exc_valid, fp_exc_flags} = {fv, f};
      {int_div_valid, int_div_zero} = {dv, dz};
      {int_div_ovf, int_mul_valid, int_mul_ovf} = {ov & dv, mv, ov & mv};
      @(posedge sys_clk);
      #1;
      {fp_exc_valid, int_div_valid, int_mul_valid} = 3'h0;
      check("fp_trap", 32'(efp), 32'(fp_trap));
      check("range_trap", 32'(erg), 32'(range_trap));
   endtask
   task automatic pulse_ptr(logic e, logic [1:0] lane);
      endian_select = e;
      @(posedge sys_clk);
      #1;
      ls_set_ptr = 1'b1;
      @(posedge sys_clk);
      #1;
      ls_set_ptr = 1'b0;
      check("byte_lane", 32'(lane), 32'(byte_lane));
   endtask
   task automatic finish_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      spr_rd(`SPR_ARITH_STATUS, 32'h0);
      check("byte_lane", 32'h3, 32'(byte_lane));
      spr_wr(`SPR_FLOAT_ENV, 32'hFFFFFFFF);
      spr_rd(`SPR_FLOAT_ENV, 32'h1FF);
      check("fast_float_en", 32'h1, 32'(fast_float_en));
      for (int m = 0; m < 4; m++) begin
         spr_wr(`SPR_FLOAT_ENV, 32'(m) << 6);
         check("round_mode", 32'(m), 32'(round_mode_field));
      end
      spr_wr(`SPR_WHOLE_TRAPS, 32'hFFFFFFFF);
      spr_rd(`SPR_WHOLE_TRAPS, 32'h3);
      spr_wr(8'h87, 32'hFF);
      spr_rd(8'h87, 32'h0);
      // Each cause traps only with its own mask bit clear
      for (int i = 0; i < 6; i++) begin
         spr_wr(`SPR_FLOAT_ENV, 32'h3F ^ (32'h1 << i));
         trap(1, 6'h3F ^ (6'h01 << i), 0, 0, 0, 0, 0, 0);
         trap(1, 6'h01 << i, 0, 0, 0, 0, 1, 0);
      end
      spr_wr(`SPR_WHOLE_TRAPS, 32'h0);
      trap(0, 6'h00, 1, 0, 0, 1, 0, 1);
      trap(0, 6'h00, 0, 0, 1, 1, 0, 1);
      spr_wr(`SPR_WHOLE_TRAPS, 32'h3);
      trap(0, 6'h00, 1, 0, 0, 1, 0, 0);
      trap(0, 6'h00, 0, 0, 1, 1, 0, 0);
      trap(0, 6'h00, 1, 1, 0, 0, 0, 1);
      // Pointer and funnel count, both through aliases and the status word
      spr_wr(`SPR_BYTE_PTR_ALIAS, 32'hFFFFFF40);
      spr_rd(`SPR_ARITH_STATUS, 32'h40);
      check("half_lane", 32'h0, 32'(half_lane));
      pulse_ptr(1'b1, 2'h0);
      pulse_ptr(1'b0, 2'h0);
      spr_wr(`SPR_SHIFT_ALIAS, 32'hFFFFFFE4);
      spr_rd(`SPR_ARITH_STATUS, 32'h64);
      check("funnel_out", 32'h23456789, funnel_out);
      spr_wr(`SPR_ARITH_STATUS, 32'h1F);
      @(posedge sys_clk);
      #1 check("funnel_out", 32'h4D5E6F78, funnel_out);
      spr_wr(`SPR_ARITH_STATUS, 32'h0);
      // Flag updates from the adder; status read back after the SUB, ADD, LOGIC and MSTEP ops
      i_exec_unit_model.issue(`OP_SUB, 32'h1, 32'h1, 32'h0, 1'b0);
      spr_rd(`SPR_ARITH_STATUS, 32'h180);
      i_exec_unit_model.issue(`OP_ADDC, 32'h0, 32'h0, 32'h0, 1'b0);
      check("alu_result", 32'h1, alu_result);
      i_exec_unit_model.issue(`OP_ADD, 32'h7FFFFFFF, 32'h1, 32'h0, 1'b0);
      spr_rd(`SPR_ARITH_STATUS, 32'h600);
      i_exec_unit_model.issue(`OP_LOGIC, 32'h5, 32'h3, 32'h0, 1'b0);
      spr_rd(`SPR_ARITH_STATUS, 32'h500);
      i_exec_unit_model.issue(`OP_MSTEP, 32'h80000000, 32'h0, 32'h0, 1'b0);
      spr_rd(`SPR_ARITH_STATUS, 32'h300);
      i_exec_unit_model.issue(`OP_DEND, 32'h0, 32'h0, 32'h0, 1'b1);
      check("div_sub_sel", 32'h1, 32'(div_sub_sel));
      spr_wr(`SPR_ARITH_STATUS, 32'h0);
      i_exec_unit_model.issue(`OP_DEND, 32'h0, 32'h0, 32'h0, 1'b0);
      check("div_sub_sel", 32'h1, 32'(div_sub_sel));
      i_exec_unit_model.issue(`OP_DEND, 32'h5, 32'h3, 32'h0, 1'b0);
      check("div_sub_sel", 32'h0, 32'(div_sub_sel));
      // One's-complement subtract and carry-using subtract
      ones_complement = 1'b1;
      i_exec_unit_model.issue(`OP_SUB, 32'h5, 32'h3, 32'h0, 1'b0);
      check("alu_result", 32'h1, alu_result);
      ones_complement = 1'b0;
      i_exec_unit_model.issue(`OP_SUBC, 32'h5, 32'h3, 32'h0, 1'b0);
      check("alu_result", 32'h2, alu_result);
      spr_wr(`SPR_ARITH_STATUS, 32'h0);
      i_exec_unit_model.issue(`OP_SUBC, 32'h5, 32'h3, 32'h0, 1'b0);
      check("alu_result", 32'h1, alu_result);
      // Divide step adds while the flag is clear, then shifts one in
      step_shift_in = 1'b1;
      i_exec_unit_model.issue(`OP_DSTEP, 32'h40000000, 32'h40000000, 32'h0,
                              1'b0);
      check("alu_result", 32'h1, alu_result);
      spr_rd(`SPR_ARITH_STATUS, 32'h600);
      finish_test();
   end
endmodule // test_arith_env_and_status_flags
